// ---- logic/cod_decoder.v ----
// Extended-opcode decoder with APB register access and operand evaluation
//
// Added by the designer: the APB interface to the registers and the register addresses.
`include "cod_consts.vh"

// Behaviour
// - Opcode 80 decodes as unconditional relative jump.
// - Opcode 3A decrements accumulator only.
// - Opcode 1A increments accumulator only.
// - Opcode DA pushes X, implied.
// - Opcode 5A pushes Y, implied.
// - Opcodes FA and 7A pull X and Y, implied.
// - Opcodes 9C, 9E, 64, 74 store zero to memory.
// - Opcodes 1C, 14 test against accumulator then clear selected bits.
// - Opcodes 0C, 04 test against accumulator then set selected bits.
// - Opcode 89 bit-tests accumulator against immediate byte.
// - Opcodes x F with bit 7 low branch if zero-page bit clear.
// - Opcodes x F with bit 7 high branch if zero-page bit set.
// - Opcodes x7 with bit 7 low clear one zero-page bit.
// - Opcodes x7 with bit 7 high set one zero-page bit.
// - Bit number comes from opcode bits 6:4; lower nibble picks group.
// - A family variant may omit the four per-bit groups.
// - Decode register transfers among A, X, Y and stack pointer.
// - Decode clear C, D, I, V and set C, D, I.
// - Decode push and pull of accumulator and status.
module cod_decoder #(
  parameter HAS_BITOPS = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg [5:0] op_class_o,
  output reg [2:0] addr_mode_o,
  output reg [2:0] bit_sel_o,
  output reg op_valid_o
);

  // ************************************************************
  // Decode functions
  // ************************************************************
  function [8:0] dec_op;
    input [7:0] op;
    input bitops;
    reg [5:0] cl;
    reg [2:0] am;
    begin
      cl = `COD_CL_NONE;
      am = `COD_AM_IMPLIED;
      case (op)
        `COD_OP_JUMP_ALWAYS: begin
          cl = `COD_CL_JUMP_ALWAYS;
          am = `COD_AM_RELATIVE;
        end
        `COD_OP_ACC_DEC: begin
          cl = `COD_CL_ACC_DEC;
          am = `COD_AM_ACCUM;
        end
        `COD_OP_ACC_INC: begin
          cl = `COD_CL_ACC_INC;
          am = `COD_AM_ACCUM;
        end
        `COD_OP_PUSH_X: cl = `COD_CL_PUSH_X;
        `COD_OP_PUSH_Y: cl = `COD_CL_PUSH_Y;
        `COD_OP_PULL_X: cl = `COD_CL_PULL_X;
        `COD_OP_PULL_Y: cl = `COD_CL_PULL_Y;
        `COD_OP_STZ_ABS: begin
          cl = `COD_CL_STZ;
          am = `COD_AM_ABS;
        end
        `COD_OP_STZ_ABSX: begin
          cl = `COD_CL_STZ;
          am = `COD_AM_ABSX;
        end
        `COD_OP_STZ_ZP: begin
          cl = `COD_CL_STZ;
          am = `COD_AM_ZP;
        end
        `COD_OP_STZ_ZPX: begin
          cl = `COD_CL_STZ;
          am = `COD_AM_ZPX;
        end
        `COD_OP_TCB_ABS: begin
          cl = `COD_CL_TCB;
          am = `COD_AM_ABS;
        end
        `COD_OP_TCB_ZP: begin
          cl = `COD_CL_TCB;
          am = `COD_AM_ZP;
        end
        `COD_OP_TSTB_ABS: begin
          cl = `COD_CL_TSTB;
          am = `COD_AM_ABS;
        end
        `COD_OP_TSTB_ZP: begin
          cl = `COD_CL_TSTB;
          am = `COD_AM_ZP;
        end
        `COD_OP_BIT_IMM: begin
          cl = `COD_CL_BIT_IMM;
          am = `COD_AM_IMM;
        end
        `COD_OP_TAX: cl = `COD_CL_TAX;
        `COD_OP_TAY: cl = `COD_CL_TAY;
        `COD_OP_TXA: cl = `COD_CL_TXA;
        `COD_OP_TYA: cl = `COD_CL_TYA;
        `COD_OP_SP_TO_X: cl = `COD_CL_SP_TO_X;
        `COD_OP_X_TO_SP: cl = `COD_CL_X_TO_SP;
        `COD_OP_CLR_C: cl = `COD_CL_CLR_C;
        `COD_OP_CLR_D: cl = `COD_CL_CLR_D;
        `COD_OP_CLR_I: cl = `COD_CL_CLR_I;
        `COD_OP_CLR_V: cl = `COD_CL_CLR_V;
        `COD_OP_SET_C: cl = `COD_CL_SET_C;
        `COD_OP_SET_D: cl = `COD_CL_SET_D;
        `COD_OP_SET_I: cl = `COD_CL_SET_I;
        `COD_OP_PUSH_A: cl = `COD_CL_PUSH_A;
        `COD_OP_PULL_A: cl = `COD_CL_PULL_A;
        `COD_OP_PUSH_P: cl = `COD_CL_PUSH_P;
        `COD_OP_PULL_P: cl = `COD_CL_PULL_P;
        default: begin
          // Per-bit groups: low nibble picks group, bit 7 picks polarity
          if (bitops && op[3:0] == `COD_LO_BRANCH_BIT) begin
            cl = op[7] ? `COD_CL_JMP_BSET : `COD_CL_JMP_BCLR;
            am = `COD_AM_ZP;
          end else if (bitops && op[3:0] == `COD_LO_MOD_BIT) begin
            cl = op[7] ? `COD_CL_SET_MBIT : `COD_CL_CLR_MBIT;
            am = `COD_AM_ZP;
          end
        end
      endcase
      dec_op = {cl, am};
    end
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  reg [31:0] ctrl;
  reg [7:0] opcode;
  reg [7:0] acc;
  reg [7:0] operand;
  reg [15:0] next_pc;
  reg [7:0] result;
  reg zero_flag;
  reg bit_state;
  reg branch_taken;
  reg [15:0] branch_target;
  reg decode_go;

  wire bitops_on = (HAS_BITOPS != 0) && !ctrl[`COD_CTRL_NO_BITOPS];
  wire [8:0] dec = dec_op(opcode, bitops_on);
  wire [5:0] cls = dec[8:3];
  wire [2:0] bsel = opcode[6:4];
  wire [7:0] bmask = 8'h01 << bsel;
  wire [15:0] rel_target = next_pc + {{8{operand[7]}}, operand};

  wire wr = psel_i && penable_i && pwrite_i && !pready_o;
  wire rd = psel_i && penable_i && !pwrite_i && !pready_o;
  wire hit = (paddr_i == `COD_REG_CTRL) || (paddr_i == `COD_REG_OPCODE) ||
    (paddr_i == `COD_REG_DECODE) || (paddr_i == `COD_REG_OPERAND) ||
    (paddr_i == `COD_REG_RESULT) || (paddr_i == `COD_REG_BRANCH);

  // ************************************************************
  // Operation evaluation
  // ************************************************************
  reg [7:0] next_result;
  reg next_zero;
  reg next_taken;
  always @* begin
    next_result = operand;
    next_zero = zero_flag;
    next_taken = 1'b0;
    case (cls)
      `COD_CL_JUMP_ALWAYS: next_taken = 1'b1;
      `COD_CL_ACC_DEC: next_result = acc - 8'h01;
      `COD_CL_ACC_INC: next_result = acc + 8'h01;
      `COD_CL_STZ: next_result = 8'h00;
      `COD_CL_TCB: begin
        next_zero = (acc & operand) == 8'h00;
        next_result = operand & ~acc;
      end
      `COD_CL_TSTB: begin
        next_zero = (acc & operand) == 8'h00;
        next_result = operand | acc;
      end
      `COD_CL_BIT_IMM: next_zero = (acc & operand) == 8'h00;
      `COD_CL_JMP_BCLR: next_taken = !operand[bsel];
      `COD_CL_JMP_BSET: next_taken = operand[bsel];
      `COD_CL_CLR_MBIT: next_result = operand & ~bmask;
      `COD_CL_SET_MBIT: next_result = operand | bmask;
      default: next_result = operand;
    endcase
  end

  // ************************************************************
  // APB slave and state
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl <= `COD_CTRL_RESET;
      opcode <= 8'h00;
      acc <= 8'h00;
      operand <= 8'h00;
      next_pc <= 16'h0000;
      result <= 8'h00;
      zero_flag <= 1'b0;
      bit_state <= 1'b0;
      branch_taken <= 1'b0;
      branch_target <= 16'h0000;
      decode_go <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      op_class_o <= `COD_CL_NONE;
      addr_mode_o <= `COD_AM_IMPLIED;
      bit_sel_o <= 3'd0;
      op_valid_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= (wr || rd) && !hit;
      decode_go <= 1'b0;
      if (wr) begin
        case (paddr_i)
          `COD_REG_CTRL: ctrl <= {31'h0000_0000,
            pwdata_i[`COD_CTRL_NO_BITOPS]};
          `COD_REG_OPCODE: begin
            opcode <= pwdata_i[7:0];
            decode_go <= 1'b1;
          end
          `COD_REG_OPERAND: begin
            operand <= pwdata_i[7:0];
            acc <= pwdata_i[15:8];
            next_pc <= pwdata_i[31:16];
          end
          default: ;
        endcase
      end
      if (rd) begin
        case (paddr_i)
          `COD_REG_CTRL: prdata_o <= ctrl;
          `COD_REG_OPCODE: prdata_o <= {24'h000000, opcode};
          `COD_REG_DECODE: prdata_o <= {19'h00000, op_valid_o,
            bit_sel_o, addr_mode_o, op_class_o};
          `COD_REG_OPERAND: prdata_o <= {next_pc, acc, operand};
          `COD_REG_RESULT: prdata_o <= {22'h000000, bit_state,
            zero_flag, result};
          `COD_REG_BRANCH: prdata_o <= {15'h0000, branch_taken,
            branch_target};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end else begin
        prdata_o <= 32'h0000_0000;
      end
      // Evaluate one cycle after opcode write so inputs are settled
      if (decode_go) begin
        op_class_o <= cls;
        addr_mode_o <= dec[2:0];
        bit_sel_o <= bsel;
        op_valid_o <= cls != `COD_CL_NONE;
        result <= next_result;
        zero_flag <= next_zero;
        bit_state <= operand[bsel];
        branch_taken <= next_taken;
        branch_target <= next_taken ? rel_target : next_pc;
      end
    end
  end

endmodule // cod_decoder

// ---- logic/cod_consts.vh ----
// Opcode values, field positions and register map for the opcode decoder
`ifndef COD_CONSTS_VH
`define COD_CONSTS_VH

// Extended opcodes
`define COD_OP_JUMP_ALWAYS 8'h80
`define COD_OP_ACC_DEC 8'h3a
`define COD_OP_ACC_INC 8'h1a
`define COD_OP_PUSH_X 8'hda
`define COD_OP_PUSH_Y 8'h5a
`define COD_OP_PULL_X 8'hfa
`define COD_OP_PULL_Y 8'h7a
`define COD_OP_STZ_ABS 8'h9c
`define COD_OP_STZ_ABSX 8'h9e
`define COD_OP_STZ_ZP 8'h64
`define COD_OP_STZ_ZPX 8'h74
`define COD_OP_TCB_ABS 8'h1c
`define COD_OP_TCB_ZP 8'h14
`define COD_OP_TSTB_ABS 8'h0c
`define COD_OP_TSTB_ZP 8'h04
`define COD_OP_BIT_IMM 8'h89
`define COD_LO_BRANCH_BIT 4'hf
`define COD_LO_MOD_BIT 4'h7

// Transfer, flag and stack opcodes
`define COD_OP_TAX 8'haa
`define COD_OP_TAY 8'ha8
`define COD_OP_TXA 8'h8a
`define COD_OP_TYA 8'h98
`define COD_OP_SP_TO_X 8'hba
`define COD_OP_X_TO_SP 8'h9a
`define COD_OP_CLR_C 8'h18
`define COD_OP_CLR_D 8'hd8
`define COD_OP_CLR_I 8'h58
`define COD_OP_CLR_V 8'hb8
`define COD_OP_SET_C 8'h38
`define COD_OP_SET_D 8'hf8
`define COD_OP_SET_I 8'h78
`define COD_OP_PUSH_A 8'h48
`define COD_OP_PULL_A 8'h68
`define COD_OP_PUSH_P 8'h08
`define COD_OP_PULL_P 8'h28

// Decoded class codes
`define COD_CL_NONE 6'd0
`define COD_CL_JUMP_ALWAYS 6'd1
`define COD_CL_ACC_DEC 6'd2
`define COD_CL_ACC_INC 6'd3
`define COD_CL_PUSH_X 6'd4
`define COD_CL_PUSH_Y 6'd5
`define COD_CL_PULL_X 6'd6
`define COD_CL_PULL_Y 6'd7
`define COD_CL_STZ 6'd8
`define COD_CL_TCB 6'd9
`define COD_CL_TSTB 6'd10
`define COD_CL_BIT_IMM 6'd11
`define COD_CL_JMP_BCLR 6'd12
`define COD_CL_JMP_BSET 6'd13
`define COD_CL_CLR_MBIT 6'd14
`define COD_CL_SET_MBIT 6'd15
`define COD_CL_TAX 6'd16
`define COD_CL_TAY 6'd17
`define COD_CL_TXA 6'd18
`define COD_CL_TYA 6'd19
`define COD_CL_SP_TO_X 6'd20
`define COD_CL_X_TO_SP 6'd21
`define COD_CL_CLR_C 6'd22
`define COD_CL_CLR_D 6'd23
`define COD_CL_CLR_I 6'd24
`define COD_CL_CLR_V 6'd25
`define COD_CL_SET_C 6'd26
`define COD_CL_SET_D 6'd27
`define COD_CL_SET_I 6'd28
`define COD_CL_PUSH_A 6'd29
`define COD_CL_PULL_A 6'd30
`define COD_CL_PUSH_P 6'd31
`define COD_CL_PULL_P 6'd32

// Addressing mode codes
`define COD_AM_IMPLIED 3'd0
`define COD_AM_ACCUM 3'd1
`define COD_AM_RELATIVE 3'd2
`define COD_AM_ABS 3'd3
`define COD_AM_ABSX 3'd4
`define COD_AM_ZP 3'd5
`define COD_AM_ZPX 3'd6
`define COD_AM_IMM 3'd7

// APB register byte offsets
`define COD_REG_CTRL 12'h000
`define COD_REG_OPCODE 12'h004
`define COD_REG_DECODE 12'h008
`define COD_REG_OPERAND 12'h00c
`define COD_REG_RESULT 12'h010
`define COD_REG_BRANCH 12'h014

// Field positions and reset values
`define COD_CTRL_NO_BITOPS 0
`define COD_CTRL_RESET 32'h0000_0000

`endif

// ---- verification/cod_prog_mem.sv ----
// Program memory model holding the opcode bytes fed to the decoder
module cod_prog_mem (
  input wire logic [5:0] addr_i,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Opcode store, one byte per address
  // ****************************************
  logic [7:0] rom [0:32];
  initial begin
    rom = '{8'h80, 8'h3a, 8'h1a, 8'hda, 8'h5a, 8'hfa, 8'h7a, 8'h9c, 8'h9e,
      8'h64, 8'h74, 8'h1c, 8'h14, 8'h0c, 8'h04, 8'h89, 8'haa, 8'ha8, 8'h8a,
      8'h98, 8'hba, 8'h9a, 8'h18, 8'hd8, 8'h58, 8'hb8, 8'h38, 8'hf8, 8'h78,
      8'h48, 8'h68, 8'h08, 8'h28};
  end
  assign byte_o = rom[addr_i];
endmodule // cod_prog_mem

// ---- verification/cod_decoder_asserts.sv ----
// Checker for the bus timing and opcode decode of cod_decoder
module cod_decoder_chk #(
  parameter HAS_BITOPS = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [5:0] op_class_o,
  input wire [2:0] addr_mode_o,
  input wire [2:0] bit_sel_o,
  input wire op_valid_o
);
  // ****************************************
  // Opcode write tracking and assertions
  // ****************************************
  reg [7:0] wr_op;
  reg [1:0] age;
  reg ctl;
  reg en;
  wire acc_w = psel_i && penable_i && pready_o && pwrite_i;
  wire mapped = paddr_i[1:0] == 2'b00 && paddr_i <= 12'h014;
  wire grp = wr_op[3:0] == 4'hf || wr_op[3:0] == 4'h7;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      age <= 2'd0;
      ctl <= 1'b0;
      en <= 1'b0;
      wr_op <= 8'h00;
    end else begin
      if (acc_w && paddr_i == 12'h004) begin
        wr_op <= pwdata_i[7:0];
        en <= HAS_BITOPS != 0 && !ctl;
        age <= 2'd1;
      end else if (age == 2'd1 || age == 2'd2) begin
        age <= age + 2'd1;
      end
      if (acc_w && paddr_i == 12'h000) begin
        ctl <= pwdata_i[0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_idle;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_err;
    pready_o |-> pslverr_o == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("wrong error flag");
  property p_valid;
    op_valid_o == (op_class_o != 6'd0);
  endproperty
  a_valid: assert property (p_valid) else $error("valid mismatch");
  property p_bitsel;
    age == 2'd3 |-> bit_sel_o == wr_op[6:4];
  endproperty
  a_bitsel: assert property (p_bitsel) else $error("bit select");
  property p_jump;
    age == 2'd3 && wr_op == 8'h80 |-> op_class_o == 6'd1 && addr_mode_o == 3'd2;
  endproperty
  a_jump: assert property (p_jump) else $error("jump decode");
  property p_brgrp;
    age == 2'd3 && en && wr_op[3:0] == 4'hf |->
      op_class_o == (wr_op[7] ? 6'd13 : 6'd12);
  endproperty
  a_brgrp: assert property (p_brgrp) else $error("bit jump");
  property p_modgrp;
    age == 2'd3 && en && wr_op[3:0] == 4'h7 |->
      op_class_o == (wr_op[7] ? 6'd15 : 6'd14);
  endproperty
  a_modgrp: assert property (p_modgrp) else $error("bit modify");
  property p_off;
    age == 2'd3 && !en && grp |-> op_class_o == 6'd0;
  endproperty
  a_off: assert property (p_off) else $error("group not off");
  c_jump: cover property (age == 2'd3 && wr_op == 8'h80);
  c_err: cover property (pready_o && pslverr_o);
  c_off: cover property (age == 2'd3 && !en && grp);
endmodule // cod_decoder_chk

bind cod_decoder cod_decoder_chk #(.HAS_BITOPS(HAS_BITOPS)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .op_class_o(op_class_o), .addr_mode_o(addr_mode_o),
  .bit_sel_o(bit_sel_o), .op_valid_o(op_valid_o));

// ---- verification/tb_cod_decoder.sv ----
// Self-checking testbench for the opcode decoder
module tb_cod_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic op_valid_o;
  logic [5:0] op_class_o;
  logic [2:0] addr_mode_o;
  logic [2:0] bit_sel_o;
  logic [5:0] idx = 6'd0;
  logic [7:0] mem_byte;
  logic [31:0] q;
  logic [31:0] w;
  logic e;
  integer failures = 0;
  integer checks = 0;
  logic [8:0] exp_tab [0:32];
  always #2 clk_i = ~clk_i;
  cod_decoder #(.HAS_BITOPS(1)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .op_class_o(op_class_o),
    .addr_mode_o(addr_mode_o), .bit_sel_o(bit_sel_o),
    .op_valid_o(op_valid_o));
  cod_prog_mem mem_u (.addr_i(idx), .byte_o(mem_byte));
  // ****************************************
  // Bus tasks and scenarios
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic run(input logic [7:0] op, input logic [31:0] word);
    apb(1'b1, 12'h00c, word);
    apb(1'b1, 12'h004, {24'h0, op});
    repeat (2) @(posedge clk_i);
  endtask
  task automatic res(input logic [11:0] a, input logic [7:0] op,
    input logic [31:0] word, input logic [31:0] m, input logic [31:0] x);
    run(op, word);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask
  task end_of_test;
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    exp_tab = '{9'h00a, 9'h011, 9'h019, 9'h020, 9'h028, 9'h030, 9'h038,
      9'h043, 9'h044, 9'h045, 9'h046, 9'h04b, 9'h04d, 9'h053, 9'h055,
      9'h05f, 9'h080, 9'h088, 9'h090, 9'h098, 9'h0a0, 9'h0a8, 9'h0b0,
      9'h0b8, 9'h0c0, 9'h0c8, 9'h0d0, 9'h0d8, 9'h0e0, 9'h0e8, 9'h0f0,
      9'h0f8, 9'h100};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({25'h0, op_valid_o, op_class_o}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h01c, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 33; i++) begin
      idx <= i[5:0];
      @(posedge clk_i);
      run(mem_byte, 32'h0);
      w = {19'h0, 1'b1, mem_byte[6:4], exp_tab[i][2:0], exp_tab[i][8:3]};
      chk({26'h0, op_class_o}, {26'h0, w[5:0]});
      apb(1'b0, 12'h008, 32'h0);
      chk(q, w);
    end
    for (int h = 0; h < 16; h++) begin
      run({h[3:0], 4'hf}, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(q, {19'h0, 1'b1, h[2:0], 3'h5, 5'h06, h[3]});
      run({h[3:0], 4'h7}, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(q, {19'h0, 1'b1, h[2:0], 3'h5, 5'h07, h[3]});
    end
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h1);
    run(8'h8f, 32'h0);
    chk({25'h0, op_valid_o, op_class_o}, 32'h0);
    run(8'h77, 32'h0);
    chk({25'h0, op_valid_o, op_class_o}, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    res(12'h010, 8'h04, 32'h0000_0f31, 32'h1ff, 32'h03f);
    res(12'h010, 8'h14, 32'h0000_0f30, 32'h1ff, 32'h130);
    res(12'h010, 8'h1c, 32'h0000_0ff3, 32'h1ff, 32'h0f0);
    res(12'h010, 8'h1a, 32'h0000_ff00, 32'h0ff, 32'h000);
    res(12'h010, 8'h3a, 32'h0000_0000, 32'h0ff, 32'h0ff);
    res(12'h010, 8'h64, 32'h0000_0055, 32'h0ff, 32'h000);
    res(12'h010, 8'hb7, 32'h0000_0000, 32'h0ff, 32'h008);
    res(12'h010, 8'h47, 32'h0000_00ff, 32'h0ff, 32'h0ef);
    res(12'h010, 8'h89, 32'h0000_f00f, 32'h100, 32'h100);
    res(12'h010, 8'h89, 32'h0000_8101, 32'h100, 32'h000);
    res(12'h014, 8'h80, 32'h1000_00fe, 32'h1_ffff, 32'h1_0ffe);
    res(12'h014, 8'h80, 32'h10f0_0020, 32'h1_ffff, 32'h1_1110);
    res(12'h014, 8'h2f, 32'h2000_0004, 32'h1_ffff, 32'h0_2000);
    res(12'h014, 8'haf, 32'h2000_0004, 32'h1_0000, 32'h1_0000);
    end_of_test;
  end
endmodule // tb_cod_decoder
